// >>> rtl/smd_unit.sv
// Serial multiply-divide element with product-quotient register
`timescale 1ns/1ps
`include "smd_defs.svh"
// Contract
// - Multiply takes fifteen phase times, four bits per cycle
// - Multiply loads upper 24 operand bits each
// - Phase counter ends every multiply automatically
// - Partial product and multiplier shift right four
// - Accumulator path stays free during multiply
// - Five low multiplier bits set recoding latches
// - New partial product is sixteenth of sum
// - Recode increments from overlapping three-bit groups
// - First step zeroes partial product, lowest bit
// - Divide takes twenty-seven phase times, two bits
// - Divide loads full 26-bit divisor and dividend
// - Non-restoring quotient bit from sign comparison
// - First quotient bit inverted as sign
// - Quotient and remainder shift left two
// - Sign decisions wait for the whole operand
// - Borrow and carry formed during load
// - Second bit uses borrow or carry path
// - Second bit is xnor of bit, borrow
// - Next borrow and carry start during update
// - Result held, readable at octal address 775
// - Held multiply writes product to accumulator
// - Held multiply stops the instruction counter
module smd_unit
  import smd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire smd_req_t req_i,
  input wire smd_serial_t ser_i,
  input wire logic phase_i,
  input wire logic rd_en_i,
  input wire logic [`SMD_ADDR_W-1:0] rd_addr_i,
  output logic [`SMD_WORD_W-1:0] rd_data_o,
  output logic rd_hit_o,
  output logic done_o,
  output logic busy_o,
  output logic acc_busy_o,
  output logic hold_counter_o,
  output logic acc_wr_o,
  output logic [`SMD_WORD_W-1:0] acc_data_o
);

  // ============================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n;

  // Two-flop release of the asynchronous reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  // ============================================================
  // Declarations
  smd_state_t state_reg;
  smd_op_t op_reg;
  logic [4:0] bit_cnt_reg;
  logic [4:0] phase_cnt_reg;
  logic [3:0] step_cnt_reg;
  logic [`SMD_WORD_W-1:0] mem_sr_reg;
  logic [`SMD_WORD_W-1:0] acc_sr_reg;
  logic [`SMD_WORD_W-1:0] mem_full;
  logic [`SMD_WORD_W-1:0] acc_full;
  logic [`SMD_OPD_W-1:0] mcand_reg;
  logic [`SMD_OPD_W-1:0] mr_reg;
  logic rb_reg;
  logic [`SMD_ACC_W-1:0] pp_reg;
  logic [`SMD_ACC_W-1:0] pp_sum;
  logic [`SMD_WORD_W-1:0] dv_reg;
  logic [`SMD_REM_W-1:0] rem_reg;
  logic [`SMD_REM_W-1:0] dv_ext;
  logic [`SMD_REM_W-1:0] r_borrow;
  logic [`SMD_REM_W-1:0] r_carry;
  logic [`SMD_REM_W-1:0] r_mid;
  logic [`SMD_REM_W-1:0] r_next;
  logic q_one;
  logic q_two;
  logic first_div_reg;
  logic [`SMD_OPD_W-1:0] quo_reg;
  logic [`SMD_WORD_W-1:0] pq_reg;
  logic is_div;
  logic take;
  logic last_bit;
  logic step;
  logic finish;
  logic [4:0] phase_limit;
  logic [3:0] step_limit;

  // ============================================================
  // Control decode
  assign is_div = (op_reg == op_divide);
  assign take = ce_i && req_i.start && (state_reg == st_idle);
  // Whole operand, sign last, before any decision
  assign last_bit = ce_i && (state_reg == st_load) && ser_i.bit_en &&
                    (bit_cnt_reg == `SMD_LAST_BIT);
  assign phase_limit = is_div ? `SMD_DIV_PHASES : `SMD_MPY_PHASES;
  assign step_limit = is_div ? `SMD_DIV_STEPS : `SMD_MPY_STEPS;
  assign step = ce_i && phase_i && (state_reg == st_exec) &&
                (step_cnt_reg != step_limit);
  // Counter stops the operation at its phase budget
  assign finish = ce_i && phase_i && (state_reg == st_exec) &&
                  (phase_cnt_reg == phase_limit - 5'h01);

  // Serial words with the present bit included, lsb first
  assign mem_full = {ser_i.mem_bit, mem_sr_reg[`SMD_WORD_W-1:1]};
  assign acc_full = {ser_i.acc_bit, acc_sr_reg[`SMD_WORD_W-1:1]};

  // ============================================================
  // Sequencer state
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_idle;
      op_reg <= op_overlapped_product;
    end else if (ce_i) begin
      unique case (state_reg)
        st_idle: begin
          if (req_i.start) begin
            state_reg <= st_load;
            op_reg <= req_i.op;
          end
        end
        st_load: begin
          if (last_bit) begin
            state_reg <= st_exec;
          end
        end
        st_exec: begin
          if (finish) begin
            state_reg <= st_idle;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // Bit and phase counters; phases count from the access
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 5'h00;
      phase_cnt_reg <= 5'h00;
    end else if (take) begin
      bit_cnt_reg <= 5'h00;
      phase_cnt_reg <= 5'h00;
    end else if (ce_i && state_reg != st_idle) begin
      if (ser_i.bit_en && state_reg == st_load) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      if (phase_i) begin
        phase_cnt_reg <= phase_cnt_reg + 5'h01;
      end
    end
  end

  // Serial input shift registers, lsb first
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_sr_reg <= '0;
      acc_sr_reg <= '0;
    end else if (ce_i && state_reg == st_load && ser_i.bit_en) begin
      mem_sr_reg <= mem_full;
      acc_sr_reg <= acc_full;
    end
  end

  // ============================================================
  // Multiply datapath
  smd_booth_step u_step (
    .mcand_i(mcand_reg),
    .pp_i(pp_reg),
    .recode_i({mr_reg[3:0], rb_reg}),
    .sum_o(pp_sum)
  );

  // Operand load, recode latches and right shift by four
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mcand_reg <= '0;
      mr_reg <= '0;
      rb_reg <= 1'b0;
      pp_reg <= '0;
      step_cnt_reg <= 4'h0;
    end else if (last_bit) begin
      mcand_reg <= mem_full[`SMD_WORD_W-1:`SMD_OPD_LSB];
      mr_reg <= acc_full[`SMD_WORD_W-1:`SMD_OPD_LSB];
      rb_reg <= 1'b0;
      pp_reg <= '0;
      step_cnt_reg <= 4'h0;
    end else if (step && !is_div) begin
      // Low sum bits enter the multiplier as product bits
      mr_reg <= {pp_sum[`SMD_MPY_SHIFT-1:0],
                 mr_reg[`SMD_OPD_W-1:`SMD_MPY_SHIFT]};
      rb_reg <= mr_reg[`SMD_MPY_SHIFT-1];
      pp_reg <= $signed(pp_sum) >>> `SMD_MPY_SHIFT;
      step_cnt_reg <= step_cnt_reg + 4'h1;
    end else if (step) begin
      step_cnt_reg <= step_cnt_reg + 4'h1;
    end
  end

  // ============================================================
  // Divide datapath
  assign dv_ext = {dv_reg[`SMD_SIGN_BIT], dv_reg};
  // Both borrow and carry candidates formed together
  assign r_borrow = (rem_reg << 1) - dv_ext;
  assign r_carry = (rem_reg << 1) + dv_ext;
  // Quotient bit one when signs agree
  assign q_one = (rem_reg[`SMD_REM_W-1] == dv_reg[`SMD_SIGN_BIT]);
  assign r_mid = q_one ? r_borrow : r_carry;
  // Sign of the borrow path equals bit-xnor-borrow form
  assign q_two = (r_mid[`SMD_REM_W-1] == dv_reg[`SMD_SIGN_BIT]);
  assign r_next = q_two ? ((r_mid << 1) - dv_ext) :
                          ((r_mid << 1) + dv_ext);

  // Divide load, two quotient bits per cycle, left shift by two
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dv_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      first_div_reg <= 1'b0;
    end else if (last_bit) begin
      dv_reg <= mem_full;
      rem_reg <= {acc_full[`SMD_SIGN_BIT], acc_full};
      quo_reg <= '0;
      first_div_reg <= 1'b1;
    end else if (step && is_div) begin
      rem_reg <= r_next;
      // First bit is stored complemented as the sign
      quo_reg <= {quo_reg[`SMD_OPD_W-`SMD_DIV_SHIFT-1:0],
                  q_one ^ first_div_reg, q_two};
      first_div_reg <= 1'b0;
    end
  end

  // ============================================================
  // Result register and outputs
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pq_reg <= '0;
      done_o <= 1'b0;
      acc_wr_o <= 1'b0;
      acc_data_o <= '0;
    end else if (ce_i) begin
      done_o <= finish;
      acc_wr_o <= finish && (op_reg == op_held_product);
      if (finish) begin
        pq_reg <= is_div ? {quo_reg, 2'h0} :
                  {pp_reg[`SMD_OPD_W-1:0],
                   mr_reg[`SMD_OPD_W-1:`SMD_OPD_W-2]};
        acc_data_o <= {pp_reg[`SMD_OPD_W-1:0],
                       mr_reg[`SMD_OPD_W-1:`SMD_OPD_W-2]};
      end
    end
  end

  // Busy flags; accumulator only tied up during operand load
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b0;
      acc_busy_o <= 1'b0;
      hold_counter_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= take || (busy_o && !finish);
      acc_busy_o <= take || (acc_busy_o && !last_bit);
      // Instruction counter frozen for the held multiply
      hold_counter_o <= (take && req_i.op == op_held_product) ||
                        (hold_counter_o && !finish);
    end
  end

  // Residual-word read of the result
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= '0;
      rd_hit_o <= 1'b0;
    end else if (ce_i) begin
      rd_hit_o <= rd_en_i && (rd_addr_i == `SMD_PQ_ADDR);
      rd_data_o <= (rd_en_i && rd_addr_i == `SMD_PQ_ADDR) ? pq_reg : '0;
    end
  end

  // ============================================================
  // Checks
  property p_mpy_end;
    (finish && !is_div) |-> (phase_cnt_reg == 5'h0e) ##1 done_o;
  endproperty
  a_mpy_end: assert property (p_mpy_end)
    else $error("multiply did not end at phase fifteen");

  property p_div_end;
    (finish && is_div) |-> (phase_cnt_reg == 5'h1a) ##1 done_o;
  endproperty
  a_div_end: assert property (p_div_end)
    else $error("divide did not end at phase twenty-seven");

  property p_mr_shift;
    (step && !is_div) |=>
      (mr_reg[19:0] == $past(mr_reg[23:4])) && (rb_reg == $past(mr_reg[3]));
  endproperty
  a_mr_shift: assert property (p_mr_shift)
    else $error("multiplier did not shift by four");

  property p_first_zero;
    last_bit |=> (pp_reg == '0) && !rb_reg && (step_cnt_reg == 4'h0);
  endproperty
  a_first_zero: assert property (p_first_zero)
    else $error("first step inputs not cleared");

  property p_mpy_load;
    last_bit |=> (mcand_reg == $past(mem_full[25:2])) &&
                 (mr_reg == $past(acc_full[25:2]));
  endproperty
  a_mpy_load: assert property (p_mpy_load)
    else $error("multiply operands not loaded");

  property p_div_load;
    last_bit |=> (dv_reg == $past(mem_full)) && first_div_reg;
  endproperty
  a_div_load: assert property (p_div_load)
    else $error("divide operands not loaded");

  property p_sign_inv;
    (step && is_div && first_div_reg) |=> (quo_reg[1] == !$past(q_one));
  endproperty
  a_sign_inv: assert property (p_sign_inv)
    else $error("quotient sign not complemented");

  property p_quo_shift;
    (step && is_div) |=> (quo_reg[23:2] == $past(quo_reg[21:0]));
  endproperty
  a_quo_shift: assert property (p_quo_shift)
    else $error("quotient did not shift by two");

  property p_hold;
    (take && req_i.op == op_held_product) |=> hold_counter_o throughout
      (busy_o [*2]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter hold not raised for held multiply");

  property p_pq_read;
    (rd_en_i && ce_i && rd_addr_i == `SMD_PQ_ADDR) |=>
      rd_hit_o && (rd_data_o == $past(pq_reg));
  endproperty
  a_pq_read: assert property (p_pq_read)
    else $error("result register read wrong");

endmodule

// >>> rtl/smd_defs.svh
// Constants of the serial multiply-divide unit
`ifndef SMD_DEFS_SVH
`define SMD_DEFS_SVH

// ============================================================
// Word layout
`define SMD_WORD_W 26
`define SMD_OPD_W 24
`define SMD_ACC_W 30
`define SMD_REM_W 27
`define SMD_LAST_BIT 5'h19
`define SMD_SIGN_BIT 25
`define SMD_OPD_LSB 2

// ============================================================
// Phase budgets, access phase included
`define SMD_MPY_PHASES 5'h0f
`define SMD_DIV_PHASES 5'h1b
`define SMD_MPY_STEPS 4'h6
`define SMD_DIV_STEPS 4'hc
`define SMD_MPY_SHIFT 4
`define SMD_DIV_SHIFT 2

// ============================================================
// Residual word address of the product-quotient register
`define SMD_ADDR_W 9
`define SMD_PQ_ADDR 9'h1fd

`endif

// >>> rtl/smd_pkg.sv
// Types shared by the serial multiply-divide unit
package smd_pkg;

  // ============================================================
  // Operation codes
  typedef enum logic [1:0] {
    op_overlapped_product = 2'b00,
    op_held_product = 2'b01,
    op_divide = 2'b10
  } smd_op_t;

  // ============================================================
  // Sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_load = 2'b01,
    st_exec = 2'b10
  } smd_state_t;

  // Start request from the program-control sequencer
  typedef struct packed {
    logic start;
    smd_op_t op;
  } smd_req_t;

  // Serial operand streams, one bit per bit strobe
  typedef struct packed {
    logic bit_en;
    logic mem_bit;
    logic acc_bit;
  } smd_serial_t;

endpackage

// >>> rtl/smd_booth_step.sv
// One radix-16 recoded multiply step: partial product plus two increments
`timescale 1ns/1ps
`include "smd_defs.svh"
module smd_booth_step
  import smd_pkg::*;
(
  input wire logic [`SMD_OPD_W-1:0] mcand_i,
  input wire logic [`SMD_ACC_W-1:0] pp_i,
  input wire logic [4:0] recode_i,
  output logic [`SMD_ACC_W-1:0] sum_o
);

  // ============================================================
  // Recoder: bits lowest first, gives 0, +-2M or +-4M
  function automatic logic [`SMD_ACC_W-1:0] smd_recode(
    input logic [2:0] bits,
    input logic [`SMD_ACC_W-1:0] m
  );
    logic [`SMD_ACC_W-1:0] r;
    r = '0;
    unique case (bits)
      3'h0, 3'h7: r = '0;
      3'h1, 3'h2: r = m << 1;
      3'h3: r = m << 2;
      3'h4: r = -(m << 2);
      3'h5, 3'h6: r = -(m << 1);
    endcase
    return r;
  endfunction

  logic [`SMD_ACC_W-1:0] m_ext;
  logic [`SMD_ACC_W-1:0] inc_one;
  logic [`SMD_ACC_W-1:0] inc_two;

  // Sign-extended multiplicand
  assign m_ext = {{(`SMD_ACC_W-`SMD_OPD_W){mcand_i[`SMD_OPD_W-1]}}, mcand_i};
  // First increment from the three lowest bits
  assign inc_one = smd_recode(recode_i[2:0], m_ext);
  // Second increment from the overlapping bits, times four
  assign inc_two = smd_recode(recode_i[4:2], m_ext) << 2;
  // Sum before the divide by sixteen
  assign sum_o = pp_i + inc_one + inc_two;

endmodule

// >>> verif/smd_partner.sv
// Sequencer and serial operand stream model facing the multiply-divide unit
`timescale 1ns/1ps
module smd_partner
  import smd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic go_i,
  input wire logic slow_i,
  input wire smd_op_t op_i,
  input wire logic [25:0] mem_i,
  input wire logic [25:0] acc_i,
  output smd_req_t req_o,
  output smd_serial_t ser_o,
  output logic phase_o
);
  // ============================================================
  // Pacing state
  logic [4:0] bit_cnt;
  logic loading;
  logic pace;
  logic [2:0] ph_cnt;
  logic emit;

  // Strobe every cycle, or every other cycle when slow
  assign emit = (req_o.start || loading) && (pace || !slow_i);

  // Start pulse, free phase pulses, serial bits
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_o <= '0;
      ser_o <= '0;
      phase_o <= 1'b0;
      bit_cnt <= 5'h0;
      loading <= 1'b0;
      pace <= 1'b0;
      ph_cnt <= 3'h0;
    end else begin
      req_o.start <= go_i;
      req_o.op <= op_i;
      pace <= ~pace;
      ph_cnt <= ph_cnt + 3'h1;
      phase_o <= slow_i ? (ph_cnt == 3'h7) : (ph_cnt[1:0] == 2'h3);
      if (emit) begin
        // Lsb first, sign bit last, all 26 bits
        ser_o.bit_en <= 1'b1;
        ser_o.mem_bit <= mem_i[bit_cnt];
        ser_o.acc_bit <= acc_i[bit_cnt];
        bit_cnt <= (bit_cnt == 5'h19) ? 5'h0 : bit_cnt + 5'h1;
        loading <= (bit_cnt != 5'h19);
      end else begin
        // Lines show no stale value between strobes
        ser_o.bit_en <= 1'b0;
        ser_o.mem_bit <= ~ser_o.mem_bit;
        ser_o.acc_bit <= ~ser_o.acc_bit;
        if (req_o.start) begin
          loading <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the serial multiply-divide unit
`timescale 1ns/1ps
`include "smd_defs.svh"
module tb
  import smd_pkg::*;
;
  // ============================================================
  // Stimulus and observed signals
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic slow = 1'b0;
  logic rd_en_i = 1'b0;
  logic [8:0] rd_addr_i = 9'h0;
  smd_op_t op = op_overlapped_product;
  logic [25:0] mem_w = 26'h0;
  logic [25:0] acc_w = 26'h0;
  smd_req_t req;
  smd_serial_t ser;
  logic phase;
  logic [25:0] rd_data;
  logic [25:0] acc_data;
  logic rd_hit, done, busy, acc_busy, hold, acc_wr;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #25 mclk_i = ~mclk_i;

  smd_unit i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .req_i(req), .ser_i(ser), .phase_i(phase), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data), .rd_hit_o(rd_hit),
    .done_o(done), .busy_o(busy), .acc_busy_o(acc_busy),
    .hold_counter_o(hold), .acc_wr_o(acc_wr), .acc_data_o(acc_data));

  smd_partner i_partner (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .go_i(go), .slow_i(slow), .op_i(op), .mem_i(mem_w), .acc_i(acc_w),
    .req_o(req), .ser_o(ser), .phase_o(phase));

  // ============================================================
  // Compare and report
  task automatic chk_bit(input logic got, input logic exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask

  task automatic chk_word(input logic [25:0] got, input logic [25:0] exp,
                          input string s);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Fractional product of the upper 24 bits, 25 fraction bits kept
  function automatic logic [25:0] mul_exp(input logic [25:0] m,
                                          input logic [25:0] a);
    longint p;
    p = longint'($signed(m[25:2])) * longint'($signed(a[25:2]));
    return 26'(p >>> 21);
  endfunction

  // Non-restoring quotient, sign bit complemented, low two bits zero
  function automatic logic [25:0] div_exp(input logic [25:0] dv,
                                          input logic [25:0] dvd);
    longint r, d;
    logic [25:0] w;
    logic q;
    r = longint'($signed(dvd));
    d = longint'($signed(dv));
    w = 26'h0;
    for (int i = 0; i < 24; i++) begin
      q = (r < 0) == (d < 0);
      w[25 - i] = (i == 0) ? ~q : q;
      r = 2 * r + (q ? -d : d);
    end
    return w;
  endfunction

  // One-cycle residual word read
  task automatic read_pq(input logic [8:0] a, input logic [25:0] exp);
    @(posedge mclk_i);
    rd_en_i <= 1'b1;
    rd_addr_i <= a;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    #1;
    chk_bit(rd_hit, a == `SMD_PQ_ADDR, "read hit");
    chk_word(rd_data, exp, "read data");
  endtask

  // ============================================================
  // One operation, watched cycle by cycle, then read back
  task automatic run_op(input smd_op_t o, input logic [25:0] m,
                        input logic [25:0] a, input logic s,
                        input logic [25:0] exp);
    int nph, tgt, nstr, lastb, n;
    logic held;
    n = (o == op_divide) ? int'(`SMD_DIV_PHASES) : int'(`SMD_MPY_PHASES);
    held = (o == op_held_product);
    nph = 0;
    tgt = -1;
    nstr = 0;
    lastb = -5;
    @(posedge mclk_i);
    op <= o;
    mem_w <= m;
    acc_w <= a;
    slow <= s;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk_i);
      #1;
      chk_bit(done, i == tgt, "done");
      chk_bit(acc_wr, held && i == tgt, "acc write");
      if (i == 1) chk_bit(acc_busy, 1'b1, "load");
      if (i == lastb + 1) chk_bit(acc_busy, 1'b0, "acc free");
      if (i >= 1 && (tgt < 0 || i < tgt)) begin
        chk_bit(busy, 1'b1, "busy");
        chk_bit(hold, held, "hold");
      end
      if (i == tgt) begin
        chk_bit(busy, 1'b0, "busy end");
        chk_bit(hold, 1'b0, "hold end");
        if (held) chk_word(acc_data, exp, "acc data");
        break;
      end
      if (ser.bit_en) begin
        nstr++;
        if (nstr == 26) begin
          lastb = i;
          chk_bit(acc_busy, 1'b1, "acc still loading");
        end
      end
      if (phase) begin
        nph++;
        if (nph == n) tgt = i + 1;
      end
    end
    if (tgt < 0) chk_bit(1'b0, 1'b1, "no finish");
    read_pq(`SMD_PQ_ADDR, exp);
    read_pq(9'h1fc, 26'h0);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_mul_fast;
    run_op(op_overlapped_product, 26'h1234567, 26'h3a00007,
           1'b0, mul_exp(26'h1234567, 26'h3a00007));
  endtask

  task automatic t_mul_patterns;
    run_op(op_overlapped_product, 26'h2c3b5a1, 26'h16e4d2c,
           1'b0, mul_exp(26'h2c3b5a1, 26'h16e4d2c));
  endtask

  task automatic t_mul_held_slow;
    run_op(op_held_product, 26'h3fffffd, 26'h2000002,
           1'b1, mul_exp(26'h3fffffd, 26'h2000002));
  endtask

  task automatic t_div_pos;
    run_op(op_divide, 26'h1800000, 26'h0400001,
           1'b0, div_exp(26'h1800000, 26'h0400001));
  endtask

  task automatic t_div_neg_slow;
    run_op(op_divide, 26'h2800000, 26'h0c00003,
           1'b1, div_exp(26'h2800000, 26'h0c00003));
  endtask

  // Clock enable low: start and read are both ignored
  task automatic t_ce_hold;
    @(posedge mclk_i);
    ce <= 1'b0;
    op <= op_divide;
    go <= 1'b1;
    rd_en_i <= 1'b1;
    rd_addr_i <= `SMD_PQ_ADDR;
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk_bit(busy, 1'b0, "start while frozen");
    chk_bit(rd_hit, 1'b0, "read while frozen");
    @(posedge mclk_i);
    ce <= 1'b1;
    rd_en_i <= 1'b0;
    repeat (32) @(posedge mclk_i);
    #1;
    chk_bit(busy, 1'b0, "no late start");
  endtask

  // Cycle ceiling against hangs
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] %0t run exceeded cycle ceiling", $time);
      final_report;
    end
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_mul_fast;
    t_mul_patterns;
    t_mul_held_slow;
    t_div_pos;
    t_div_neg_slow;
    t_ce_hold;
    final_report;
  end
endmodule
